// file: rtl/asc_serial_ctrl.sv
// serial control port loading the step attenuator word
`timescale 1ns/1ps
`include "asc_params.svh"
// What this block does
// - shift one bit per rising clock, MSB first
// - serial clock ignored while load strobe high
// - reset word gives minimum gain
// - serial bits become six-bit parallel word
// - load strobe transfers shifted word to outputs
// - bit weights 0.5 to 16 dB, ones max gain
// - all 64 word values accepted
module asc_serial_ctrl (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic serialClk,
    input wire logic serial_in_line,
    input wire logic load_strobe,
    output asc_pkg::asc_word_type gain_attenuation_word,
    output logic atten_bit_16db,
    output logic atten_bit_half_db
);
    logic sclkSync;
    logic dataSync;
    logic strobeSync;
    logic sclk_q;
    logic strobe_q;
    logic shiftEdge;
    logic strobeRise;
    asc_pkg::asc_word_type shift_q;
    asc_pkg::asc_word_type shift_d;

    // each pin gets its own two-flop stage
    asc_sync u_sclk (
        .clk(clk),
        .reset_n(reset_n),
        .pinIn(serialClk),
        .pinSync(sclkSync)
    );
    asc_sync u_data (
        .clk(clk),
        .reset_n(reset_n),
        .pinIn(serial_in_line),
        .pinSync(dataSync)
    );
    asc_sync u_strobe (
        .clk(clk),
        .reset_n(reset_n),
        .pinIn(load_strobe),
        .pinSync(strobeSync)
    );

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sclk_q <= 1'b0;
            strobe_q <= 1'b0;
        end else begin
            sclk_q <= sclkSync;
            strobe_q <= strobeSync;
        end
    end

    assign shiftEdge = sclkSync && !sclk_q && !strobeSync;
    assign strobeRise = strobeSync && !strobe_q;
    assign shift_d = {shift_q[4:0], dataSync};

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            shift_q <= `ASC_RESET_WORD;
        end else if (shiftEdge) begin
            shift_q <= shift_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            gain_attenuation_word <= `ASC_RESET_WORD;
        end else if (strobeRise) begin
            gain_attenuation_word <= shift_q;
        end
    end

    assign atten_bit_16db = gain_attenuation_word[5];
    assign atten_bit_half_db = gain_attenuation_word[0];

    // checks below sample pins as well as core state; a pin seen at one
    // edge reaches the core logic two edges later through the synchroniser
    // pin-level events, as sampled by the system clock
    sequence s_clk_pin_rise;
        $rose(serialClk) && !load_strobe;
    endsequence

    sequence s_clk_pin_gated;
        $rose(serialClk) && load_strobe;
    endsequence

    sequence s_strobe_pin_rise;
        $rose(load_strobe);
    endsequence

    // core events, two edges after the pin events above
    sequence s_core_shift;
        shiftEdge;
    endsequence

    sequence s_core_load;
        strobeRise;
    endsequence

    a_word_reset: assert property (
        @(posedge clk)
        $rose(reset_n) |-> gain_attenuation_word == `ASC_RESET_WORD)
        else $error("word not at min gain after reset");

    // sync reset: both registers back to maximum attenuation
    a_reset_hold: assert property (
        @(posedge clk)
        !reset_n |=> gain_attenuation_word == `ASC_RESET_WORD
            && shift_q == `ASC_RESET_WORD)
        else $error("reset did not restore min gain");

    a_shift_order: assert property (
        @(posedge clk) disable iff (!reset_n)
        s_core_shift |=> shift_q == {$past(shift_q[4:0]), $past(dataSync)})
        else $error("shift wrong order");

    // edge detector must give one shift per serial clock rise
    a_edge_once: assert property (
        @(posedge clk) disable iff (!reset_n)
        s_core_shift |=> !shiftEdge)
        else $error("one clock rise shifted twice");

    // end to end: pin data at the rise lands in the lsb
    a_pin_shift: assert property (
        @(posedge clk) disable iff (!reset_n)
        s_clk_pin_rise |-> ##3
            shift_q == {$past(shift_q[4:0]), $past(serial_in_line, 3)})
        else $error("pin bit not shifted in");

    // synchroniser depth; the guard skips edges that reset has cleared
    a_data_sync: assert property (
        @(posedge clk) disable iff (!reset_n)
        $past(reset_n) && $past(reset_n, 2)
            |-> dataSync == $past(serial_in_line, 2))
        else $error("data synchroniser depth wrong");

    a_clk_sync: assert property (
        @(posedge clk) disable iff (!reset_n)
        $past(reset_n) && $past(reset_n, 2)
            |-> sclkSync == $past(serialClk, 2))
        else $error("clock synchroniser depth wrong");

    a_strobe_sync: assert property (
        @(posedge clk) disable iff (!reset_n)
        $past(reset_n) && $past(reset_n, 2)
            |-> strobeSync == $past(load_strobe, 2))
        else $error("strobe synchroniser depth wrong");

    a_strobe_gate: assert property (
        @(posedge clk) disable iff (!reset_n)
        strobeSync |=> $stable(shift_q))
        else $error("shift during strobe");

    a_gate_core: assert property (
        @(posedge clk) disable iff (!reset_n)
        strobeSync |-> !shiftEdge)
        else $error("edge detected while strobe high");

    // a rise that meets the strobe high at the pin must shift nothing
    a_pin_gate: assert property (
        @(posedge clk) disable iff (!reset_n)
        s_clk_pin_gated |-> ##3 $stable(shift_q))
        else $error("gated clock rise shifted");

    a_word_load: assert property (
        @(posedge clk) disable iff (!reset_n)
        s_core_load |=> gain_attenuation_word == $past(shift_q))
        else $error("word not loaded on strobe");

    a_strobe_once: assert property (
        @(posedge clk) disable iff (!reset_n)
        s_core_load |=> !strobeRise)
        else $error("one strobe loaded twice");

    // latency is three system clocks after the strobe pin rises
    a_pin_load: assert property (
        @(posedge clk) disable iff (!reset_n)
        s_strobe_pin_rise |-> ##3 gain_attenuation_word == $past(shift_q))
        else $error("strobe pin did not apply word");

    // a strobe held high must not reload the word
    a_level_no_load: assert property (
        @(posedge clk) disable iff (!reset_n)
        strobeSync && strobe_q |=> $stable(gain_attenuation_word))
        else $error("held strobe reloaded word");

    a_word_hold: assert property (
        @(posedge clk) disable iff (!reset_n)
        !strobeRise |=> $stable(gain_attenuation_word))
        else $error("word changed without strobe");

    a_bit_map: assert property (
        @(posedge clk) disable iff (!reset_n)
        atten_bit_16db == gain_attenuation_word[5]
            && atten_bit_half_db == gain_attenuation_word[0])
        else $error("bit outputs mismapped");

    a_any_value: assert property (
        @(posedge clk) disable iff (!reset_n)
        s_core_load ##0 shift_q == `ASC_MAX_GAIN_WORD
            |=> gain_attenuation_word == `ASC_MAX_GAIN_WORD)
        else $error("all-ones word not applied");

    a_keep_last: assert property (
        @(posedge clk) disable iff (!reset_n)
        s_core_shift ##1 !shiftEdge |-> shift_q[0] == $past(dataSync))
        else $error("latest bit not in lsb");
endmodule : asc_serial_ctrl

// file: shared/asc_params.svh
// constants for the attenuator serial control block
`ifndef ASC_PARAMS_SVH
`define ASC_PARAMS_SVH
`define ASC_WORD_BITS 6
`define ASC_RESET_WORD 6'h00
`define ASC_MAX_GAIN_WORD 6'h3f
`define ASC_SYNC_STAGES 2
`endif

// file: shared/asc_pkg.sv
// types for the attenuator serial control block
`include "asc_params.svh"
package asc_pkg;
    typedef logic [`ASC_WORD_BITS-1:0] asc_word_type;
endpackage : asc_pkg

// file: rtl/asc_sync.sv
// two-flop synchroniser for one pin
`timescale 1ns/1ps
module asc_sync (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic pinIn,
    output logic pinSync
);
    logic meta_q;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            meta_q <= 1'b0;
            pinSync <= 1'b0;
        end else begin
            meta_q <= pinIn;
            pinSync <= meta_q;
        end
    end
endmodule : asc_sync

// file: test/asc_host_model.sv
// host model driving the three serial pins
`timescale 1ns/1ps
module asc_host_model (
    output logic serialClk,
    output logic serial_in_line,
    output logic load_strobe
);
    initial {serialClk, serial_in_line, load_strobe} = 3'h0;
    // data set up 40 ns before the rise and held 30 ns after it
    task automatic bit1(input logic b);
        serial_in_line = b;
        #40 serialClk = 1'b1;
        // line shows the inverse once hold time has passed
        #30 serial_in_line = ~b;
        #10 serialClk = 1'b0;
    endtask : bit1
    task automatic hold(input logic s);
        #40 load_strobe = s;
    endtask : hold
    // strobe well after the last rise, then spaced
    task automatic latch();
        hold(1'b1);
        #60 load_strobe = 1'b0;
        #630;
    endtask : latch
endmodule : asc_host_model

// file: test/asc_serial_ctrl_tb_top.sv
// bench for the attenuator serial control block
`timescale 1ns/1ps
module asc_serial_ctrl_tb_top;
    logic clk, reset_n, sck, sdi, stb, b16, bHalf;
    asc_pkg::asc_word_type word;
    int miscompares = 0;
    int total_checks = 0;
    asc_host_model host (.serialClk(sck), .serial_in_line(sdi),
        .load_strobe(stb));
    asc_serial_ctrl uut (.clk(clk), .reset_n(reset_n), .serialClk(sck),
        .serial_in_line(sdi), .load_strobe(stb),
        .gain_attenuation_word(word), .atten_bit_16db(b16),
        .atten_bit_half_db(bHalf));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input asc_pkg::asc_word_type e);
        total_checks++;
        if (word !== e || b16 !== e[5] || bHalf !== e[0]) begin
            miscompares++;
            $display("[FAIL] word exp %h seen %h", e, word);
        end
    endtask : check
    task automatic send(input asc_pkg::asc_word_type v);
        for (int i = 5; i >= 0; i--) host.bit1(v[i]);
    endtask : send
    task automatic t_weights();
        asc_pkg::asc_word_type t [9] = '{6'h3f, 6'h3e, 6'h3d, 6'h3b,
            6'h37, 6'h2f, 6'h1f, 6'h00, 6'h2a};
        asc_pkg::asc_word_type p = 6'h00;
        foreach (t[i]) begin
            send(t[i]);
            check(p);
            host.latch();
            check(t[i]);
            p = t[i];
        end
    endtask : t_weights
    task automatic t_gate();
        send(6'h15);
        host.latch();
        host.hold(1'b1);
        send(6'h2a);
        host.hold(1'b0);
        #120;
        host.latch();
        check(6'h15);
    endtask : t_gate
    task automatic t_extra();
        host.bit1(1'b1);
        host.bit1(1'b0);
        send(6'h0c);
        host.latch();
        check(6'h0c);
    endtask : t_extra
    task automatic t_reset();
        send(6'h2d);
        host.latch();
        check(6'h2d);
        reset_n = 1'b0;
        #20 reset_n = 1'b1;
        #30;
        check(6'h00);
    endtask : t_reset
    task automatic summarize();
        if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize
    initial begin
        reset_n = 1'b0;
        repeat (12) @(posedge clk);
        #1 reset_n = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check(6'h00);
        t_weights();
        t_gate();
        t_extra();
        t_reset();
        summarize();
    end
    initial begin
        #100000;
        miscompares++;
        summarize();
    end
endmodule : asc_serial_ctrl_tb_top
